// *** scm_readout.sv ***
// Serial configuration memory: read-out, cascade, standby and programming entry
`timescale 1ns/1ns
module scm_readout (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Loader side controls
  input wire logic LOADER_CONFIG_CLOCK,
  input wire logic RESET_OE,
  input wire logic CHIP_SELECT_N,
  input wire logic PROGRAM_MODE_SELECT_N,
  // Programming qualifiers
  input wire logic DEVICE_SELECT_PIN,
  input wire logic WRITE_GUARD_ONE,
  input wire logic WRITE_GUARD_TWO,
  input wire logic PGM_WRITE,
  input wire scm_pkg::scm_idx_t PGM_ADDR,
  input wire logic PGM_CFG_WRITE,
  input wire logic [7:0] PGM_CFG_BYTE,
  // Data pin
  input wire logic DATA_I,
  output logic DATA_O,
  output logic DATA_OE,
  // Cascade and status
  output logic CHAIN_SELECT_OUT_N,
  output logic READY_O,
  output logic READY_OE,
  output logic STANDBY
);
  import scm_pkg::*;

  typedef struct packed {
    logic [4:0] por_cnt;
    logic ready;
    scm_idx_t idx;
    logic done;
    logic clk_prev;
    logic data_o;
    logic data_oe;
    logic chain_n;
    logic ready_oe;
    logic standby;
    logic [SCM_POL_BYTES-1:0][7:0] pol;
  } scm_state_t;

  scm_state_t s_q;
  scm_state_t s_d;
  logic serial_mode;
  logic pol_inv;
  logic oe_act;
  logic selected;
  logic clk_rise;
  logic adv;
  logic prog_sel;
  logic guarded;
  logic wr_ok;
  logic rd_bit;

  // ---------------------------------------------------------------
  // Mode and qualifiers
  // ---------------------------------------------------------------
  assign serial_mode = PROGRAM_MODE_SELECT_N;
  // Polarity flips only when every stored byte says so; an erased part keeps default
  assign pol_inv = (s_q.pol == {SCM_POL_BYTES{SCM_POL_INVERT}});
  assign oe_act = pol_inv ? !RESET_OE : RESET_OE;
  assign selected = serial_mode && !CHIP_SELECT_N;
  assign clk_rise = LOADER_CONFIG_CLOCK && !s_q.clk_prev;
  assign adv = clk_rise && selected && oe_act && s_q.ready && !s_q.done;
  assign prog_sel = !serial_mode && DEVICE_SELECT_PIN;
  assign guarded = PGM_ADDR[SCM_HALF_BIT] ? WRITE_GUARD_TWO : WRITE_GUARD_ONE;
  assign wr_ok = prog_sel && PGM_WRITE && !guarded && s_q.ready;

  scm_bit_store u_store (
    .clk(CORE_CLK),
    .nrst(NRST),
    .we(wr_ok),
    .waddr(PGM_ADDR),
    .wdata(DATA_I),
    .raddr(s_q.idx),
    .rdata(rd_bit)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.clk_prev = LOADER_CONFIG_CLOCK;
    // Power-on cycle: counter held clear and ready pulled low until it ends
    if (!s_q.ready) begin
      s_d.idx = SCM_IDX_ZERO;
      s_d.done = 1'b0;
      if (s_q.por_cnt == SCM_POR_CYCLES - SCM_POR_ONE) begin
        s_d.ready = 1'b1;
      end else begin
        s_d.por_cnt = s_q.por_cnt + SCM_POR_ONE;
      end
    end else if (!oe_act) begin
      s_d.idx = SCM_IDX_ZERO;
      s_d.done = 1'b0;
    end else if (adv) begin
      if (s_q.idx == SCM_IDX_LAST) begin
        s_d.done = 1'b1;
      end else begin
        s_d.idx = s_q.idx + SCM_IDX_ONE;
      end
    end
    // Cascade: low while selected and enabled after the end, tracks select
    s_d.chain_n = !(s_d.done && oe_act && selected);
    s_d.ready_oe = !s_d.ready;
    s_d.standby = selected == 1'b0 && serial_mode;
    if (serial_mode) begin
      // Output-only during loading: float on reset level, standby or after the end
      s_d.data_oe = oe_act && selected && s_d.ready && !s_d.done;
      s_d.data_o = rd_bit;
    end else begin
      // Open-drain in programming: pull low one cycle to acknowledge a write
      s_d.data_oe = wr_ok;
      s_d.data_o = 1'b0;
      if (prog_sel && PGM_CFG_WRITE && s_q.ready) begin
        s_d.pol[PGM_ADDR[1:0]] = PGM_CFG_BYTE;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q.por_cnt <= SCM_POR_ZERO;
      s_q.ready <= 1'b0;
      s_q.idx <= SCM_IDX_ZERO;
      s_q.done <= 1'b0;
      s_q.clk_prev <= 1'b0;
      s_q.data_o <= 1'b0;
      s_q.data_oe <= 1'b0;
      s_q.chain_n <= 1'b1;
      s_q.ready_oe <= 1'b1;
      s_q.standby <= 1'b0;
      s_q.pol <= {SCM_POL_BYTES{SCM_POL_ERASED}};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign DATA_O = s_q.data_o;
  assign DATA_OE = s_q.data_oe;
  assign CHAIN_SELECT_OUT_N = s_q.chain_n;
  assign READY_O = s_q.data_o & 1'b0;
  assign READY_OE = s_q.ready_oe;
  assign STANDBY = s_q.standby;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  a_reset_clears_all: assert property (
    s_q.ready && !oe_act |=> s_q.idx == SCM_IDX_ZERO && !DATA_OE && !s_q.done
  ) else $error("reset level did not clear counters or float data");

  a_drive_needs_both: assert property (
    DATA_OE && $past(serial_mode) |-> $past(oe_act) && $past(!CHIP_SELECT_N)
  ) else $error("data driven without enable and select");

  a_clock_advances: assert property (
    adv && s_q.idx != SCM_IDX_LAST |=> s_q.idx == $past(s_q.idx) + SCM_IDX_ONE
  ) else $error("loader clock did not advance the counter");

  a_standby_holds: assert property (
    s_q.ready && serial_mode && CHIP_SELECT_N && oe_act |=> $stable(s_q.idx) && STANDBY
  ) else $error("counter moved or no standby while deselected");

  a_standby_floats: assert property (
    STANDBY |-> !DATA_OE
  ) else $error("data driven in standby");

  a_prog_ignores_select: assert property (
    !serial_mode && s_q.ready && oe_act |=> $stable(s_q.idx) && !STANDBY
  ) else $error("select acted during programming mode");

  a_cascade_asserts: assert property (
    adv && s_q.idx == SCM_IDX_LAST ##1 oe_act && selected |=> !CHAIN_SELECT_OUT_N
  ) else $error("cascade output not low after final bit");

  a_cascade_follows: assert property (
    s_q.done && oe_act && serial_mode |=> CHAIN_SELECT_OUT_N == $past(CHIP_SELECT_N)
  ) else $error("cascade output not following select");

  a_end_floats: assert property (
    s_q.done |=> !DATA_OE || !serial_mode
  ) else $error("data still driven after the end of the array");

  a_ready_power_on: assert property (
    !s_q.ready |-> READY_OE && !READY_O
  ) else $error("ready released during power-on cycle");

  a_guard_blocks: assert property (
    PGM_WRITE && WRITE_GUARD_ONE && WRITE_GUARD_TWO |-> !wr_ok
  ) else $error("write accepted through a guard");

  c_bit_advance: cover property (adv ##[1:20] adv);
  c_cascade_low: cover property ($fell(CHAIN_SELECT_OUT_N));
  c_prog_write: cover property (wr_ok ##1 DATA_OE);
  c_polarity_flip: cover property ($rose(pol_inv));
endmodule

// *** scm_pkg.sv ***
// Shared constants and types of the serial configuration memory read-out
package scm_pkg;
  localparam int unsigned SCM_IDX_W = 20;
  localparam int unsigned SCM_MEM_BITS = 1048576;
  localparam logic [19:0] SCM_IDX_ZERO = 20'h00000;
  localparam logic [19:0] SCM_IDX_ONE = 20'h00001;
  localparam logic [19:0] SCM_IDX_LAST = 20'hfffff;
  localparam int unsigned SCM_HALF_BIT = 19;
  localparam logic [4:0] SCM_POR_CYCLES = 5'h10;
  localparam logic [4:0] SCM_POR_ZERO = 5'h00;
  localparam logic [4:0] SCM_POR_ONE = 5'h01;
  localparam logic [7:0] SCM_POL_ERASED = 8'hff;
  localparam logic [7:0] SCM_POL_INVERT = 8'h00;
  localparam int unsigned SCM_POL_BYTES = 4;

  typedef logic [19:0] scm_idx_t;
endpackage

// *** scm_bit_store.sv ***
// Bit-wide storage array with a registered read port and a write port
`timescale 1ns/1ns
module scm_bit_store (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Write side
  input wire logic we,
  input wire scm_pkg::scm_idx_t waddr,
  input wire logic wdata,
  // Read side
  input wire scm_pkg::scm_idx_t raddr,
  output logic rdata
);
  import scm_pkg::*;

  typedef struct packed {
    logic rdata;
  } scm_store_t;

  // No reset on the array: contents stand for non-volatile cells
  logic mem [SCM_MEM_BITS];
  scm_store_t s_q;
  scm_store_t s_d;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = mem[raddr];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
endmodule

// *** scm_loader_model.sv ***
// Loader model: master serial loader that clocks the memory and samples its data line
`timescale 1ns/1ns
module scm_loader_model (
  // Core clock
  input wire logic clk,
  // Data pin of the memory
  input wire logic data_o,
  input wire logic data_oe,
  // Loader side
  output logic loader_config_clock,
  output logic seen
);
  logic line = 1'b0;
  initial loader_config_clock = 1'b0;
  // A released line shows a toggling level, so a stale bit shows only on every other cycle
  always @(posedge clk) begin
    line <= data_oe ? data_o : ~line;
  end
  assign seen = line;
  // Each level held three core cycles; the memory sees the rise at the next core clock edge, half a core cycle after it
  task automatic pulse();
    @(negedge clk);
    loader_config_clock = 1'b1;
    repeat (3) @(negedge clk);
    loader_config_clock = 1'b0;
    repeat (3) @(negedge clk);
  endtask
endmodule

// *** tb.sv ***
// Self-checking testbench of the serial configuration memory read-out
`timescale 1ns/1ns
module tb;
  import scm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rst_oe = 1'b1;
  logic cs_n = 1'b0;
  logic pms_n = 1'b0;
  logic dsel = 1'b1;
  logic wg1 = 1'b0;
  logic wg2 = 1'b0;
  logic pw = 1'b0;
  logic pcw = 1'b0;
  logic di = 1'b0;
  logic [7:0] pbyte = 8'h00;
  scm_idx_t paddr = 20'h00000;
  logic lclk, d_o, doe, ceo_n, rdy, rdy_oe, stby, seen;
  logic [3:0] pat = 4'hd;
  int bad_count = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  scm_loader_model ldr (.clk(clk), .data_o(d_o), .data_oe(doe),
    .loader_config_clock(lclk), .seen(seen));
  scm_readout uut (.CORE_CLK(clk), .NRST(nrst), .LOADER_CONFIG_CLOCK(lclk),
    .RESET_OE(rst_oe), .CHIP_SELECT_N(cs_n), .PROGRAM_MODE_SELECT_N(pms_n),
    .DEVICE_SELECT_PIN(dsel), .WRITE_GUARD_ONE(wg1), .WRITE_GUARD_TWO(wg2),
    .PGM_WRITE(pw), .PGM_ADDR(paddr), .PGM_CFG_WRITE(pcw), .PGM_CFG_BYTE(pbyte),
    .DATA_I(di), .DATA_O(d_o), .DATA_OE(doe), .CHAIN_SELECT_OUT_N(ceo_n),
    .READY_O(rdy), .READY_OE(rdy_oe), .STANDBY(stby));

  task automatic chk(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Write one bit and look for the one-cycle acknowledge pull-down
  task automatic pwrite(input scm_idx_t a, input logic b, input logic ack);
    paddr = a;
    di = b;
    pw = 1'b1;
    cyc(1);
    pw = 1'b0;
    chk("write ack", ack, doe);
    cyc(1);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200us;
    bad_count++;
    print_verdict();
  end

  initial begin
    cyc(8);
    chk("ready pull", 1'b1, rdy_oe);
    nrst = 1'b1;
    for (int k = 0; k < 40 && rdy_oe !== 1'b0; k++) cyc(1);
    chk("ready release", 1'b0, rdy_oe);
    $display("test power-on done");
    for (int i = 0; i < 4; i++) pwrite(i[19:0], pat[i], 1'b1);
    wg1 = 1'b1;
    pwrite(20'h00005, 1'b1, 1'b0);
    wg1 = 1'b0;
    wg2 = 1'b1;
    pwrite(20'h80005, 1'b1, 1'b0);
    wg2 = 1'b0;
    dsel = 1'b0;
    pwrite(20'h00006, 1'b1, 1'b0);
    dsel = 1'b1;
    $display("test programming done");
    pms_n = 1'b1;
    rst_oe = 1'b0;
    cyc(2);
    rst_oe = 1'b1;
    cyc(4);
    chk("drive enable", 1'b1, doe);
    chk("first bit", pat[0], seen);
    chk("ready value", 1'b0, rdy);
    chk("cascade idle", 1'b1, ceo_n);
    for (int i = 1; i < 4; i++) begin
      ldr.pulse();
      chk("next bit", pat[i], seen);
    end
    cs_n = 1'b1;
    cyc(2);
    chk("standby", 1'b1, stby);
    chk("standby float", 1'b0, doe);
    ldr.pulse();
    cs_n = 1'b0;
    cyc(4);
    chk("held bit", pat[3], seen);
    rst_oe = 1'b0;
    cyc(2);
    chk("reset float", 1'b0, doe);
    rst_oe = 1'b1;
    cyc(4);
    chk("rewound bit", pat[0], seen);
    $display("test read-out done");
    pms_n = 1'b0;
    cs_n = 1'b1;
    cyc(2);
    chk("select ignored", 1'b0, stby);
    chk("program float", 1'b0, doe);
    for (int i = 0; i < 4; i++) begin
      paddr = i[19:0];
      pcw = 1'b1;
      cyc(1);
      pcw = 1'b0;
      cyc(1);
    end
    pms_n = 1'b1;
    cs_n = 1'b0;
    rst_oe = 1'b1;
    cyc(4);
    chk("inverted reset", 1'b0, doe);
    rst_oe = 1'b0;
    cyc(4);
    chk("inverted enable", 1'b1, doe);
    $display("test polarity done");
    print_verdict();
  end
endmodule
